/* File: dcr_pkg.sv */
package dcr_pkg;
    // Register space
    localparam int          NUM_REGS     = 28;
    localparam int          NUM_PAR_REGS = 112;
    localparam logic [4:0]  REG_CTL1     = 5'h00;
    localparam logic [4:0]  REG_CTL2     = 5'h01;
    localparam logic [4:0]  REG_LAST     = 5'h1b;
    localparam logic [4:0]  REG_USR0     = 5'h1b;
    localparam logic [6:0]  PAR_LAST     = 7'h6f;

    // First control register fields
    localparam int          CAL_BIT      = 24;
    localparam int          STREAM_BIT   = 17;
    localparam int          SINE_BIT     = 16;
    localparam int          RATE_BIT     = 15;
    localparam int          AUTO_RAMP    = 14;
    localparam int          AUTO_PHASE   = 13;
    localparam int          CLR_RAMP     = 12;
    localparam int          CLR_PHASE    = 11;
    // Second control register: ramp generator enable
    localparam int          RAMP_EN_BIT  = 19;

    // Write masks and reset values
    localparam logic [31:0] CTL1_MASK    = 32'h0103_fbff;
    localparam logic [31:0] USR0_MASK    = 32'h00ff_ffff;
    localparam logic [31:0] FULL_MASK    = 32'hffff_ffff;
    localparam logic [31:0] CTL1_RST     = 32'h0001_0000;
    localparam logic [31:0] USR0_RST     = 32'h0000_0800;
    localparam logic [31:0] OTHER_RST    = 32'h0000_0000;

    // Parallel function pin codes and word destinations
    localparam logic [3:0]  FUNC_FREQ    = 4'h0;
    localparam logic [3:0]  FUNC_PHASE   = 4'h1;
    localparam logic [3:0]  FUNC_AMPL    = 4'h2;
    localparam logic [1:0]  DEST_FREQ    = 2'h0;
    localparam logic [1:0]  DEST_PHASE   = 2'h1;
    localparam logic [1:0]  DEST_AMPL    = 2'h2;
    localparam logic [31:0] PHASE_MASK   = 32'h0000_ffff;
    localparam logic [31:0] AMPL_MASK    = 32'h0000_0fff;

    typedef struct packed {
        logic        en;
        logic        par;
        logic [6:0]  addr;
        logic [31:0] data;
    } dcr_wr_t;

    typedef struct packed {
        logic        en;
        logic        par;
        logic [6:0]  addr;
    } dcr_rd_t;

    typedef struct packed {
        logic [1:0]  dest;
        logic [31:0] data;
    } dcr_pword_t;
endpackage : dcr_pkg

/* File: dcr_top.sv */
// What this block does
// - Decode 28 word or 112 byte registers
// - Staged writes move on update or profile
// - Bit 24 rising starts one PLL calibration
// - Non-streaming parallel words latch on update
// - Streaming samples parallel pins every cycle
// - Bit 16 selects sine, default sine
// - Bit 15 reloads ramp rate if ramp
// - Bit 14 clears ramp accumulator one cycle
// - Auto clears apply at edge after update, static holds one edge later
// - Bit 13 clears phase on update
// - Bit 12 holds ramp accumulator cleared
// - Bit 11 holds phase accumulator cleared
// - Master reset restores all defaults
module dcr_top (
    input  wire logic               clk_sys,
    input  wire logic               srst,
    input  wire dcr_pkg::dcr_wr_t   host_wr,
    input  wire dcr_pkg::dcr_rd_t   host_rd,
    output logic [31:0]             rd_data,
    output logic                    rd_valid,
    input  wire logic               io_update,
    input  wire logic [2:0]         profile_select_pins,
    input  wire logic [31:0]        parallel_data,
    input  wire logic [3:0]         parallel_function_pins,
    output logic                    par_ready,
    output dcr_pkg::dcr_pword_t     word_out,
    output logic                    word_valid,
    input  wire logic               word_ready,
    output logic                    sine_select,
    output logic                    vco_cal_start,
    output logic                    rate_load,
    output logic                    ramp_acc_clear,
    output logic                    phase_acc_clear,
    output logic [31:0]             ctrl1_active
);
    import dcr_pkg::*;

    logic [31:0] stage_q  [NUM_REGS];
    logic [31:0] active_q [NUM_REGS];
    logic [2:0]  prof_prev_q;
    logic [31:0] rd_data_q;
    logic        rd_valid_q;
    logic        cal_prev_q;
    logic        cal_start_q;
    logic        rate_load_q;
    logic        ramp_clr_q;
    logic        phase_clr_q;
    logic        sine_q;
    dcr_pword_t  head_q;
    dcr_pword_t  tail_q;
    logic        head_v_q;
    logic        tail_v_q;

    // Update event: strobe or any change of the profile pins
    wire         upd_event  = io_update | (profile_select_pins != prof_prev_q);

    // Write decode: serial word address or parallel byte address
    wire         wr_ser_hit = (host_wr.addr[6:5] == 2'b00) && (host_wr.addr[4:0] <= REG_LAST);
    wire         wr_par_hit = (host_wr.addr <= PAR_LAST);
    wire         wr_hit     = host_wr.en & (host_wr.par ? wr_par_hit : wr_ser_hit);
    wire [4:0]   wr_reg     = host_wr.par ? host_wr.addr[6:2] : host_wr.addr[4:0];
    wire [3:0]   wr_be      = host_wr.par ? (4'h1 << host_wr.addr[1:0]) : 4'hf;
    wire [31:0]  wr_word    = host_wr.par ? {4{host_wr.data[7:0]}} : host_wr.data;
    wire [31:0]  wr_bmask   = {{8{wr_be[3]}}, {8{wr_be[2]}}, {8{wr_be[1]}}, {8{wr_be[0]}}};

    // Read decode, byte lanes shifted down in parallel mode
    wire         rd_ser_hit = (host_rd.addr[6:5] == 2'b00) && (host_rd.addr[4:0] <= REG_LAST);
    wire         rd_par_hit = (host_rd.addr <= PAR_LAST);
    wire         rd_hit     = host_rd.par ? rd_par_hit : rd_ser_hit;
    wire [4:0]   rd_reg     = host_rd.par ? host_rd.addr[6:2] : host_rd.addr[4:0];
    wire [31:0]  rd_word    = rd_hit ? stage_q[rd_reg] : 32'h0000_0000;
    wire [4:0]   rd_shift   = {host_rd.addr[1:0], 3'b000};
    wire [31:0]  rd_bytes   = (rd_word >> rd_shift) & 32'h0000_00ff;
    wire [31:0]  rd_d       = host_rd.par ? rd_bytes : rd_word;

    // Staging and active copies, one per register
    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
            localparam logic [4:0]  IDX   = 5'(i);
            localparam logic [31:0] WMASK = (i == 0) ? CTL1_MASK :
                                            (i == NUM_REGS - 1) ? USR0_MASK : FULL_MASK;
            localparam logic [31:0] RSTV  = (i == 0) ? CTL1_RST :
                                            (i == NUM_REGS - 1) ? USR0_RST : OTHER_RST;
            wire  [31:0] m       = wr_bmask & WMASK;
            wire         sel     = wr_hit && (wr_reg == IDX);
            wire  [31:0] stage_d = sel ? ((stage_q[i] & ~m) | (wr_word & m)) : stage_q[i];

            // Writes land in staging at once
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    stage_q[i] <= RSTV;
                end else begin
                    stage_q[i] <= stage_d;
                end
            end

            // Active copy follows only on an update event
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    active_q[i] <= RSTV;
                end else if (upd_event) begin
                    active_q[i] <= stage_q[i];
                end
            end
        end
    endgenerate

    // Staged values moving to the active side on this event, and the current active ones
    wire [31:0]  ctl1_new   = stage_q[REG_CTL1];
    wire [31:0]  ctl1_now   = active_q[REG_CTL1];
    wire         ramp_en    = stage_q[REG_CTL2][RAMP_EN_BIT];
    wire         stream_en  = ctl1_now[STREAM_BIT];

    // Control outputs: rate and auto clears take effect at the edge after the event, calibration start one edge later
    wire         rate_d     = upd_event & ctl1_new[RATE_BIT] & ramp_en;
    wire         a_ramp_d   = upd_event & ctl1_new[AUTO_RAMP];
    wire         a_phase_d  = upd_event & ctl1_new[AUTO_PHASE];
    wire         cal_d      = ctl1_now[CAL_BIT] & ~cal_prev_q;

    // Static holds merged with one-cycle clears, so each output is one flop
    wire         rmp_clr_d  = ctl1_now[CLR_RAMP] | a_ramp_d;
    wire         phs_clr_d  = ctl1_now[CLR_PHASE] | a_phase_d;

    // Parallel port word selection
    wire         func_freq  = (parallel_function_pins == FUNC_FREQ);
    wire         func_phase = (parallel_function_pins == FUNC_PHASE);
    wire         func_ampl  = (parallel_function_pins == FUNC_AMPL);
    wire         func_ok    = func_freq | func_phase | func_ampl;
    wire [1:0]   func_dest  = func_phase ? DEST_PHASE : (func_ampl ? DEST_AMPL : DEST_FREQ);
    wire [31:0]  func_mask  = func_phase ? PHASE_MASK : (func_ampl ? AMPL_MASK : FULL_MASK);
    wire         par_take   = stream_en ? func_ok : (io_update & func_ok);
    dcr_pword_t  in_word;
    assign in_word.dest = func_dest;
    assign in_word.data = parallel_data & func_mask;

    // Two-entry buffer handshake
    wire         in_ready   = ~tail_v_q;
    wire         push       = par_take & in_ready;
    wire         pop        = head_v_q & word_ready;

    // Previous profile pins, for change detection
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prof_prev_q <= 3'h0;
        end else begin
            prof_prev_q <= profile_select_pins;
        end
    end

    // Read answer, held until the next read
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rd_data_q <= 32'h0000_0000;
        end else begin
            rd_data_q <= host_rd.en ? rd_d : rd_data_q;
        end
    end

    // Read valid pulse one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= host_rd.en;
        end
    end

    // Calibration bit history, so only a rising bit starts a run
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cal_prev_q <= 1'b0;
        end else begin
            cal_prev_q <= ctl1_now[CAL_BIT];
        end
    end

    // One-cycle calibration start pulse
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cal_start_q <= 1'b0;
        end else begin
            cal_start_q <= cal_d;
        end
    end

    // Ramp rate reload pulse
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rate_load_q <= 1'b0;
        end else begin
            rate_load_q <= rate_d;
        end
    end

    // Ramp accumulator clear: static hold or one-cycle auto clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ramp_clr_q <= 1'b0;
        end else begin
            ramp_clr_q <= rmp_clr_d;
        end
    end

    // Phase accumulator clear: static hold or one-cycle auto clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase_clr_q <= 1'b0;
        end else begin
            phase_clr_q <= phs_clr_d;
        end
    end

    // Output function select, sine after reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sine_q <= CTL1_RST[SINE_BIT];
        end else begin
            sine_q <= ctl1_now[SINE_BIT];
        end
    end

    // Buffer next state: head drives the output, tail catches a word during a stall
    wire         head_free  = pop | ~head_v_q;
    wire         head_v_d   = head_free ? (tail_v_q | push) : 1'b1;
    wire         tail_v_d   = head_free ? (tail_v_q & push) : (tail_v_q | push);
    wire         tail_take  = push & ~(head_free & ~tail_v_q);
    dcr_pword_t  head_d;
    dcr_pword_t  tail_d;
    assign head_d = (head_free && tail_v_q) ? tail_q : ((head_free && push) ? in_word : head_q);
    assign tail_d = tail_take ? in_word : tail_q;

    // Head entry valid
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            head_v_q <= 1'b0;
        end else begin
            head_v_q <= head_v_d;
        end
    end

    // Tail entry valid
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tail_v_q <= 1'b0;
        end else begin
            tail_v_q <= tail_v_d;
        end
    end

    // Head entry word
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            head_q <= '0;
        end else begin
            head_q <= head_d;
        end
    end

    // Tail entry word
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tail_q <= '0;
        end else begin
            tail_q <= tail_d;
        end
    end

    // Output ready tracks buffer space after this edge
    logic par_ready_q;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            par_ready_q <= 1'b0;
        end else begin
            par_ready_q <= ~tail_v_d;
        end
    end

    // Active first control register as seen from outside
    logic [31:0] ctl1_out_q;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctl1_out_q <= CTL1_RST;
        end else begin
            ctl1_out_q <= ctl1_now & CTL1_MASK;
        end
    end

    // Register bus answer
    assign rd_data         = rd_data_q;
    assign rd_valid        = rd_valid_q;

    // Parallel word buffer
    assign par_ready       = par_ready_q;
    assign word_out        = head_q;
    assign word_valid      = head_v_q;

    // Synthesizer controls, each straight from one flop
    assign sine_select     = sine_q;
    assign vco_cal_start   = cal_start_q;
    assign rate_load       = rate_load_q;
    assign ramp_acc_clear  = ramp_clr_q;
    assign phase_acc_clear = phase_clr_q;
    assign ctrl1_active    = ctl1_out_q;
endmodule : dcr_top

/* File: dcr_chk.sv */
module dcr_chk (
    input wire logic                clk_sys,
    input wire logic                srst,
    input wire dcr_pkg::dcr_rd_t    host_rd,
    input wire logic [31:0]         rd_data,
    input wire logic                rd_valid,
    input wire logic                io_update,
    input wire logic [2:0]          profile_select_pins,
    input wire dcr_pkg::dcr_pword_t word_out,
    input wire logic                word_valid,
    input wire logic                word_ready,
    input wire logic                sine_select,
    input wire logic                vco_cal_start,
    input wire logic                rate_load,
    input wire logic                ramp_acc_clear,
    input wire logic [31:0]         ctrl1_active
);
    timeunit 1ns;
    timeprecision 1ps;
    import dcr_pkg::*;
    logic [2:0] prof_q;
    logic       ev;
    // Update event as seen on the pins
    assign ev = !srst && (io_update || profile_select_pins != prof_q);
    // Previous profile pins
    always_ff @(posedge clk_sys) begin
        prof_q <= srst ? 3'h0 : profile_select_pins;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    read_answer_a: assert property (host_rd.en |=> rd_valid)
        else $error("no read answer");
    unmapped_zero_a: assert property (
        host_rd.en && !host_rd.par && host_rd.addr > 7'h1b |=> rd_data == 32'h0)
        else $error("unmapped read");
    open_bits_a: assert property ((ctrl1_active & ~CTL1_MASK) == 32'h0)
        else $error("open bit set");
    staged_hold_a: assert property (!ev |=> ##1 $stable(ctrl1_active))
        else $error("active moved");
    sine_follow_a: assert property (sine_select == ctrl1_active[SINE_BIT])
        else $error("sine select");
    ramp_static_a: assert property (ctrl1_active[CLR_RAMP] |-> ramp_acc_clear)
        else $error("ramp hold");
    cal_start_a: assert property ($rose(ctrl1_active[CAL_BIT]) |-> vco_cal_start)
        else $error("no cal pulse");
    rate_cause_a: assert property (rate_load |-> $past(ev))
        else $error("stray rate load");
    auto_ramp_a: assert property (
        ramp_acc_clear && !ctrl1_active[CLR_RAMP] |-> $past(ev))
        else $error("stray ramp clear");
    buffer_hold_a: assert property (word_valid && !word_ready |=> word_valid && $stable(word_out))
        else $error("word lost");
endmodule : dcr_chk

bind dcr_top dcr_chk u_dcr_chk (.*);

/* File: dcr_host.sv */
module dcr_host (
    input  wire logic        clk_sys,
    input  wire logic [31:0] rd_data,
    output dcr_pkg::dcr_wr_t host_wr,
    output dcr_pkg::dcr_rd_t host_rd,
    output logic             io_update
);
    timeunit 1ns;
    timeprecision 1ps;
    import dcr_pkg::*;
    // Idle bus at time zero
    initial begin
        host_wr = '0;
        host_rd = '0;
        io_update = 1'b0;
    end
    // One write, enable held for one cycle
    task automatic wr(input logic p, input logic [6:0] a, input logic [31:0] d);
        @(negedge clk_sys) host_wr = '{1'b1, p, a, d};
        @(negedge clk_sys) host_wr.en = 1'b0;
    endtask : wr
    // One read, answer taken the cycle after
    task automatic rd(input logic p, input logic [6:0] a, output logic [31:0] d);
        @(negedge clk_sys) host_rd = '{1'b1, p, a};
        @(negedge clk_sys) host_rd.en = 1'b0;
        d = rd_data;
    endtask : rd
    // Update strobe moves staged values
    task automatic upd;
        @(negedge clk_sys) io_update = 1'b1;
        @(negedge clk_sys) io_update = 1'b0;
    endtask : upd
endmodule : dcr_host

/* File: dcr_top_tb.sv */
module dcr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dcr_pkg::*;
    logic        clk_sys, srst, rd_valid, io_update, par_ready, word_valid, word_ready;
    logic        sine_select, vco_cal_start, rate_load, ramp_acc_clear, phase_acc_clear;
    logic [2:0]  profile_select_pins, n_r, n_p, n_l, n_v;
    logic [3:0]  parallel_function_pins;
    logic [31:0] rd_data, parallel_data, ctrl1_active, rdv;
    dcr_wr_t     host_wr;
    dcr_rd_t     host_rd;
    dcr_pword_t  word_out;
    int          n_errors = 0, check_count = 0;

    dcr_top  u_dcr_top (.*);
    dcr_host u_dcr_host (.*);

    // 200 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic rdc(input logic p, input logic [6:0] a, input logic [31:0] e);
        u_dcr_host.rd(p, a, rdv);
        check({1'b0, rd_valid, rdv}, {2'b01, e});
    endtask : rdc
    // Count high cycles of the pulse outputs
    task automatic watch;
        {n_r, n_p, n_l, n_v} = '0;
        repeat (6) begin
            n_r = n_r + {2'h0, ramp_acc_clear};
            n_p = n_p + {2'h0, phase_acc_clear};
            n_l = n_l + {2'h0, rate_load};
            n_v = n_v + {2'h0, vco_cal_start};
            @(negedge clk_sys);
        end
    endtask : watch
    task automatic set0(input logic [31:0] d);
        u_dcr_host.wr(1'b0, 7'h0, d);
        u_dcr_host.upd();
        watch();
    endtask : set0
    task automatic t_map;
        check(ctrl1_active, CTL1_RST);
        check(sine_select, 1'b1);
        rdc(1'b0, 7'h1b, USR0_RST);
        u_dcr_host.wr(1'b0, 7'h0, 32'hffff_ffff);
        rdc(1'b0, 7'h0, CTL1_MASK);
        check(ctrl1_active, CTL1_RST);
        rdc(1'b0, 7'h1c, 32'h0);
        rdc(1'b1, 7'h6d, 32'h08);
        u_dcr_host.wr(1'b1, 7'h02, 32'h0);
        rdc(1'b0, 7'h0, 32'h0100_fbff);
        $display("map test done");
    endtask : t_map
    task automatic t_clear;
        u_dcr_host.wr(1'b0, 7'h1, 32'h0008_0000);
        set0(32'h0001_e000);
        check({n_r, n_p, n_l, n_v}, {3'd1, 3'd1, 3'd1, 3'd0});
        check(ctrl1_active, 32'h0001_e000);
        @(negedge clk_sys) profile_select_pins = 3'h5;
        watch();
        check({n_r, n_p, n_l, n_v}, {3'd1, 3'd1, 3'd1, 3'd0});
        u_dcr_host.wr(1'b0, 7'h1, 32'h0);
        set0(32'h0001_8000);
        check({n_r, n_p, n_l, n_v}, 12'h0);
        set0(32'h0000_1800);
        watch();
        check({n_r, n_p, n_l, n_v}, {3'd6, 3'd6, 3'd0, 3'd0});
        check(sine_select, 1'b0);
        set0(CTL1_RST);
        watch();
        check({n_r, n_p, sine_select}, {3'd0, 3'd0, 1'b1});
        $display("clear test done");
    endtask : t_clear
    task automatic t_cal;
        set0(32'h0101_0000);
        check(n_v, 3'd1);
        u_dcr_host.upd();
        watch();
        check(n_v, 3'd0);
        set0(CTL1_RST);
        set0(32'h0101_0000);
        check(n_v, 3'd1);
        $display("cal test done");
    endtask : t_cal
    task automatic t_port;
        set0(32'h0003_0000);
        @(negedge clk_sys) parallel_function_pins = FUNC_FREQ;
        parallel_data = 32'h1234_5678;
        @(negedge clk_sys) parallel_function_pins = FUNC_PHASE;
        parallel_data = 32'h9abc_def0;
        @(negedge clk_sys) parallel_function_pins = 4'hf;
        @(negedge clk_sys) check({word_out, par_ready}, {DEST_FREQ, 32'h1234_5678, 1'b0});
        word_ready = 1'b1;
        @(negedge clk_sys) check(word_out, {DEST_PHASE, 32'h0000_def0});
        @(negedge clk_sys) check(word_valid, 1'b0);
        word_ready = 1'b0;
        set0(CTL1_RST);
        parallel_function_pins = FUNC_AMPL;
        parallel_data = 32'hffff_ffff;
        watch();
        check(word_valid, 1'b0);
        u_dcr_host.upd();
        check({word_valid, word_out}, {1'b1, DEST_AMPL, AMPL_MASK});
        $display("port test done");
    endtask : t_port
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        finish_test();
    end
    initial begin
        srst = 1'b1;
        profile_select_pins = 3'h0;
        parallel_function_pins = 4'hf;
        parallel_data = 32'h0;
        word_ready = 1'b0;
        repeat (20) @(negedge clk_sys);
        srst = 1'b0;
        t_map();
        t_clear();
        t_cal();
        t_port();
        finish_test();
    end
endmodule : dcr_top_tb
